// *** rtl/lhcd_pkg.sv ***
// Package for the display host command decoder: register map, command
// codes, bit positions, reset values and the control state record.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
package lhcd_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int         APB_ADDR_W = 8;      // Width of the APB address.
   localparam logic [7:0] OFS_CMD    = 8'h00;  // Control byte in, status out.
   localparam logic [7:0] OFS_DATA   = 8'h04;  // Display RAM data byte.
   localparam logic [7:0] OFS_PTR    = 8'h08;  // Page and column pointers.
   localparam logic [7:0] OFS_SET    = 8'h0c;  // Packed settings view.

   // ----------------------------------------------------------------------
   // Command codes and bit positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] OP_TRIM     = 8'h81;  // Bias trim, two bytes.
   localparam logic [7:0] OP_ISO      = 8'h82;  // Isolation clock, three bytes.
   localparam logic [7:0] OP_NVM_CTRL = 8'hb8;  // Non-volatile op control.
   localparam logic [7:0] OP_MAP      = 8'hc0;  // Mapping control, two bytes.
   localparam logic [7:0] OP_WIN_A    = 8'hf4;  // Window start or nvm pair.
   localparam logic [7:0] OP_WIN_B    = 8'hf6;  // Window end or nvm pair.
   localparam logic [7:0] OP_SWRESET  = 8'he2;  // Software reset.
   localparam logic [7:0] OP_SER_STAT = 8'hfe;  // Serial status stream.
   localparam int AC_WRAP  = 0;                 // Wrap enable bit.
   localparam int AC_ORDER = 1;                 // Page first when set.
   localparam int AC_DIR   = 2;                 // Page steps down when set.
   localparam int AC_WIN   = 3;                 // Window program mode.
   localparam int NVM_EN   = 3;                 // Non-volatile enable bit.
   localparam int LC_MX    = 1;                 // Column mirror bit.
   localparam int LC_MY    = 2;                 // Row mirror bit.
   localparam int DC_ON    = 2;                 // Display enable bit.
   localparam logic [2:0] DC_PATTERN = 3'b100;  // On/off, one bit per pixel.
   localparam int PATTERN_PAGES = 20;           // Pages per stored pattern.

   // ----------------------------------------------------------------------
   // Control state and its reset values
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OPCODE = 2'b00,   // Next byte is an opcode.
      ST_PARAM1 = 2'b01,   // Next byte is the first parameter.
      ST_PARAM2 = 2'b10    // Next byte is the second parameter.
   } lhcd_state_type;

   typedef struct packed {
      logic [7:0] column_pointer;
      logic [6:0] page_pointer;
      logic [7:0] scroll_offset;
      logic [3:0] fixed_row_pairs;
      logic [1:0] temp_coefficient;
      logic [3:0] pump_settings;
      logic [7:0] bias_trim;
      logic [3:0] address_step_control;
      logic [7:0] display_control;
      logic [9:0] panel_control;
      logic [5:0] nvm_op_control;
      logic [7:0] win_col_start;
      logic [6:0] win_page_start;
      logic [7:0] win_col_end;
      logic [6:0] win_page_end;
   } lhcd_ctl_type;

   localparam logic [3:0] RST_PUMP = 4'hf;      // Pump control default.
   localparam logic [7:0] RST_TRIM = 8'hea;     // Bias trim default.
   localparam lhcd_ctl_type CTL_DEFAULT = '{
      column_pointer: 8'h00, page_pointer: 7'h00, scroll_offset: 8'h00,
      fixed_row_pairs: 4'h0, temp_coefficient: 2'h0, pump_settings: RST_PUMP,
      bias_trim: RST_TRIM, address_step_control: 4'h1, display_control: 8'h18,
      panel_control: 10'h020, nvm_op_control: 6'h10, win_col_start: 8'h00,
      win_page_start: 7'h00, win_col_end: 8'hff, win_page_end: 7'h4f};

endpackage

// *** rtl/lhcd_decoder.sv ***
// Host command decoder with display RAM, address pointers and status bytes.
// Assumes an APB master on pclk; ID, offset, nvm and ESD inputs are
// synchronous to pclk.
//
// Behaviour
// R1 - Command register takes controls, data register takes pixels.
// R2 - Data access moves one byte at the pointers.
// R3 - Pointers advance after every data access.
// R4 - Without wrap, column stops at last column.
// R5 - With wrap, column clears and page steps.
// R6 - Page wraps between page 0 and 79.
// R7 - Order bit picks column-first or page-first stepping.
// R8 - First read after addressing returns stale byte.
// R9 - Status one packs mirrors, wrap, display, nvm.
// R10 - Status two packs ID pins and trim offset.
// R11 - Status three packs product code and ESD flag.
// R12 - Status reads rotate one, two, three, repeat.
// R13 - Column loaded as two nibbles, range 0..255.
// R14 - Page loaded as nibble plus three bits.
// R15 - Pattern mode splits page into pattern and page.
// R16 - Temperature coefficient two-bit field, resets to 00.
// R17 - Panel and pump halves load separately.
// R18 - Scroll offset loaded as two nibbles.
// R19 - Trim takes opcode then value, default EAH.
// R20 - Nvm enable turns window codes into nvm codes.
// R21 - Write mask and trim share one register.
// R22 - Host sends only defined command codes.
// R23 - Serial status streams until chip select drops.
// R24 - Software reset restores controls, keeps RAM.
// R25 - Multi-byte commands hold opcode, capture parameters.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module lhcd_decoder
   import lhcd_pkg::*;
#(
   parameter int         PAGE_COUNT   = 80,     // Display RAM pages.
   parameter int         COL_COUNT    = 256,    // Columns per page.
   parameter logic       VERSION_BIT  = 1'b0,   // Arbitrary version value.
   parameter logic [3:0] PRODUCT_CODE = 4'ha    // Arbitrary product value.
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [1:0]            id_pin_state,
   input  wire logic [5:0]            bias_trim_offset,
   input  wire logic                  nvm_op_success,
   input  wire logic                  nvm_option_present,
   input  wire logic                  nvm_in_progress,
   input  wire logic                  esd_strike,
   input  wire logic                  serial_eight_bit_mode,
   input  wire logic                  serial_nine_bit_mode,
   input  wire logic                  chip_select_n,
   output logic                       esd_event_flag,
   output logic [7:0]                 scroll_offset,
   output logic [1:0]                 temp_coefficient,
   output logic [3:0]                 pump_settings,
   output logic [7:0]                 bias_trim,
   output logic [7:0]                 display_control,
   output logic [9:0]                 panel_control
);

   // ----------------------------------------------------------------------
   // Constants and storage
   // ----------------------------------------------------------------------
   localparam int         RAM_W     = $clog2(PAGE_COUNT * COL_COUNT);
   localparam logic [6:0] LAST_PAGE = 7'(PAGE_COUNT - 1);
   localparam logic [7:0] LAST_COL  = 8'(COL_COUNT - 1);

   logic [7:0]     ram [PAGE_COUNT*COL_COUNT];  // Display RAM, not reset.
   lhcd_ctl_type   ctl;                         // All control registers.
   lhcd_ctl_type   next_ctl;                    // Decoded next controls.
   lhcd_state_type state;                       // Byte position in command.
   lhcd_state_type next_state;
   logic [7:0]     opcode;                      // Pending multi-byte opcode.
   logic [7:0]     next_opcode;
   logic [7:0]     read_buf;                    // Byte fetched by last read.
   logic [1:0]     stat_sel;                    // Status byte to send next.
   logic           stream;                      // Serial status stream on.

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // Steps the pointers after a data access; result is {page, column}.
   function automatic logic [14:0] step_addr(input logic [7:0] col,
                                             input logic [6:0] page,
                                             input logic [3:0] ac);
      logic [6:0] pg_next;
      logic       pg_end;
      begin
         pg_next = ac[AC_DIR] ? ((page == 7'h00) ? LAST_PAGE : page - 7'h01)
                              : ((page == LAST_PAGE) ? 7'h00 : page + 7'h01);  // R6
         pg_end  = ac[AC_DIR] ? (page == 7'h00) : (page == LAST_PAGE);
         step_addr = {page, col};                                  // R4
         if (!ac[AC_ORDER]) begin                                  // R7
            if (col != LAST_COL) begin
               step_addr = {page, col + 8'h01};                    // R3
            end else if (ac[AC_WRAP]) begin
               step_addr = {pg_next, 8'h00};                       // R5
            end
         end else begin
            if (!pg_end) begin
               step_addr = {pg_next, col};                         // R7
            end else if (ac[AC_WRAP]) begin
               step_addr = {pg_next, col + 8'h01};
            end
         end
      end
   endfunction

   // Maps the pointers to a RAM index, with mirror and pattern selection.
   function automatic logic [RAM_W-1:0] ram_index(input logic [7:0] col,
                                                  input logic [6:0] page,
                                                  input logic       mirror,
                                                  input logic       pattern);
      logic [7:0]  eff_col;
      logic [14:0] eff_page;
      begin
         eff_col  = mirror ? LAST_COL - col : col;
         eff_page = pattern ? 15'(page[6:5]) * 15'(PATTERN_PAGES) + 15'(page[4:0])
                            : 15'(page);                           // R15
         ram_index = RAM_W'(eff_page * 15'(COL_COUNT) + 15'(eff_col));  // R2
      end
   endfunction

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire        setup     = psel & ~penable;              // APB setup phase.
   wire        access    = psel & penable;               // APB access phase.
   wire        hit_cmd   = (paddr == OFS_CMD);
   wire        hit_data  = (paddr == OFS_DATA);
   wire        mapped    = hit_cmd | hit_data | (paddr == OFS_PTR) | (paddr == OFS_SET);
   wire        cmd_wr    = access & pwrite & hit_cmd;                 // R1
   wire        data_wr   = access & pwrite & hit_data;                // R1
   wire        data_rd   = access & ~pwrite & hit_data & ~stream;
   wire        stat_rd   = access & ~pwrite & (hit_cmd | (hit_data & stream));
   wire [7:0]  cbyte     = pwdata[7:0];
   wire        nvm_on    = ctl.nvm_op_control[NVM_EN];
   wire        serial_ok = serial_eight_bit_mode | serial_nine_bit_mode;
   wire        sw_reset  = cmd_wr & (state == ST_OPCODE) & (cbyte == OP_SWRESET);
   wire        pattern   = (ctl.display_control[5:3] == DC_PATTERN);
   wire [RAM_W-1:0] ram_addr = ram_index(ctl.column_pointer, ctl.page_pointer,
                                         ctl.panel_control[LC_MX], pattern);
   wire [14:0] stepped   = step_addr(ctl.column_pointer, ctl.page_pointer,
                                     ctl.address_step_control);

   // ----------------------------------------------------------------------
   // Status bytes and read mux
   // ----------------------------------------------------------------------
   wire [7:0] status_one = {VERSION_BIT, ctl.panel_control[LC_MX],
                            ctl.panel_control[LC_MY], ctl.address_step_control[AC_WRAP],
                            ctl.display_control[DC_ON], nvm_op_success,
                            nvm_option_present, nvm_in_progress};      // R9
   wire [7:0] status_two = {id_pin_state, bias_trim_offset};          // R10
   wire [7:0] status_thr = {PRODUCT_CODE, 3'b000, esd_event_flag};    // R11
   wire [7:0] status_cur = (stat_sel == 2'd0) ? status_one :
                           (stat_sel == 2'd1) ? status_two : status_thr;
   wire [31:0] settings  = {ctl.display_control, ctl.bias_trim, ctl.scroll_offset,
                            ctl.pump_settings, ctl.temp_coefficient,
                            ctl.address_step_control[AC_WRAP+1:0]};
   wire [31:0] rd_mux    = hit_cmd  ? {24'h0, status_cur} :
                           hit_data ? {24'h0, stream ? status_cur : read_buf} : // R8
                           (paddr == OFS_PTR) ? {17'h0, ctl.page_pointer,
                                                 ctl.column_pointer} :
                           (paddr == OFS_SET) ? settings : 32'h0;

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // Works out the next controls, byte position and pending opcode.
   always_comb begin
      next_ctl    = ctl;
      next_state  = state;
      next_opcode = opcode;
      if (data_wr || data_rd) begin                             // R3
         {next_ctl.page_pointer, next_ctl.column_pointer} = stepped;
      end
      if (cmd_wr) begin
         case (state)
            ST_OPCODE: begin
               casez (cbyte)
                  8'b0000????: next_ctl.column_pointer[3:0] = cbyte[3:0];   // R13
                  8'b0001????: next_ctl.column_pointer[7:4] = cbyte[3:0];   // R13
                  8'b001001??: next_ctl.temp_coefficient = cbyte[1:0];      // R16
                  8'b001010??: next_ctl.pump_settings[1:0] =                // R17
                     (cbyte[1] ^ cbyte[0]) ? RST_PUMP[1:0] : cbyte[1:0];
                  8'b001011??: next_ctl.pump_settings[3:2] =                // R17
                     (cbyte[1] ^ cbyte[0]) ? RST_PUMP[3:2] : cbyte[1:0];
                  8'b0100????: next_ctl.scroll_offset[3:0] = cbyte[3:0];    // R18
                  8'b0101????: next_ctl.scroll_offset[7:4] = cbyte[3:0];    // R18
                  8'b0110????: next_ctl.page_pointer[3:0] = cbyte[3:0];     // R14
                  8'b01110???: next_ctl.page_pointer[6:4] = cbyte[2:0];     // R14
                  8'b100001??: next_ctl.panel_control[9:8] = cbyte[1:0];
                  8'b10001???: next_ctl.address_step_control[2:0] = cbyte[2:0];
                  8'b1001????: next_ctl.fixed_row_pairs = cbyte[3:0];
                  8'b101000??: next_ctl.panel_control[5:4] = cbyte[1:0];
                  8'b1010010?: next_ctl.display_control[1] = cbyte[0];
                  8'b1010011?: next_ctl.display_control[0] = cbyte[0];
                  8'b10101???: next_ctl.display_control[4:2] = cbyte[2:0];
                  8'b11010???: next_ctl.display_control[7:5] = cbyte[2:0];
                  8'b1111100?: next_ctl.address_step_control[AC_WIN] = cbyte[0];
                  8'b0011000?, OP_TRIM, OP_ISO, OP_NVM_CTRL, OP_MAP, 8'hc8,
                  8'b111001??, 8'hf1, 8'hf2, 8'hf3, OP_WIN_A, OP_WIN_B: begin
                     next_opcode = cbyte;                                  // R25
                     next_state  = ST_PARAM1;
                  end
                  default: ;   // Undefined codes and no-operation do nothing. R22
               endcase
            end
            ST_PARAM1: begin
               next_state = ST_OPCODE;
               case (opcode)
                  OP_TRIM: next_ctl.bias_trim = nvm_on ? {2'b00, cbyte[5:0]}  // R21
                                                       : cbyte;              // R19
                  OP_NVM_CTRL: next_ctl.nvm_op_control = cbyte[5:0];
                  OP_MAP: next_ctl.panel_control[3:0] = cbyte[3:0];
                  OP_ISO: next_state = ST_PARAM2;
                  OP_WIN_A: begin
                     next_state = ST_PARAM2;
                     if (!nvm_on) next_ctl.win_col_start = cbyte;            // R20
                  end
                  OP_WIN_B: begin
                     next_state = ST_PARAM2;
                     if (!nvm_on) next_ctl.win_col_end = cbyte;              // R20
                  end
                  default: ;   // Parameters for settings held elsewhere.
               endcase
            end
            ST_PARAM2: begin
               next_state = ST_OPCODE;
               if (!nvm_on && opcode == OP_WIN_A) next_ctl.win_page_start = cbyte[6:0];
               if (!nvm_on && opcode == OP_WIN_B) next_ctl.win_page_end = cbyte[6:0];
            end
            default: next_state = ST_OPCODE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Control registers and decoder position; software reset keeps the RAM.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl    <= CTL_DEFAULT;
         state  <= ST_OPCODE;
         opcode <= 8'h00;
      end else if (sw_reset) begin
         ctl    <= CTL_DEFAULT;                                   // R24
         state  <= ST_OPCODE;
         opcode <= 8'h00;
      end else begin
         ctl    <= next_ctl;
         state  <= next_state;
         opcode <= next_opcode;
      end
   end

   // Display RAM write port, no reset so contents survive software reset.
   always_ff @(posedge pclk) begin
      if (data_wr) begin
         ram[ram_addr] <= pwdata[7:0];                            // R2
      end
   end

   // Read buffer, status rotation, serial stream and ESD flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_buf       <= 8'h00;
         stat_sel       <= 2'd0;
         stream         <= 1'b0;
         esd_event_flag <= 1'b0;
      end else begin
         if (data_rd) begin
            read_buf <= ram[ram_addr];                            // R8
         end
         if (stat_rd) begin
            stat_sel <= (stat_sel == 2'd2) ? 2'd0 : stat_sel + 2'd1;  // R12
         end else if (access) begin
            stat_sel <= 2'd0;                                     // R12
         end
         if (chip_select_n) begin
            stream <= 1'b0;                                       // R23
         end else if (cmd_wr && state == ST_OPCODE && cbyte == OP_SER_STAT && serial_ok) begin
            stream <= 1'b1;                                       // R23
         end
         if (esd_strike) begin
            esd_event_flag <= 1'b1;                               // R11
         end
      end
   end

   // APB answer: zero wait states, read data and error set up in advance.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            prdata  <= rd_mux;
            pslverr <= ~mapped;
         end
      end
   end

   // Setting outputs straight from the control registers.
   assign scroll_offset    = ctl.scroll_offset;
   assign temp_coefficient = ctl.temp_coefficient;
   assign pump_settings    = ctl.pump_settings;
   assign bias_trim        = ctl.bias_trim;
   assign display_control  = ctl.display_control;
   assign panel_control    = ctl.panel_control;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_col_advance: assert property (data_wr && !sw_reset && ctl.column_pointer != LAST_COL // R3
      && !ctl.address_step_control[AC_ORDER]
      |=> ctl.column_pointer == $past(ctl.column_pointer) + 8'h01)
      else $error("column pointer did not advance");
   chk_col_stop: assert property ((data_wr || data_rd) // R4
      && ctl.address_step_control[1:0] == 2'b00 && ctl.column_pointer == LAST_COL
      |=> ctl.column_pointer == LAST_COL)
      else $error("column pointer moved past last column");
   chk_col_wrap: assert property ((data_wr || data_rd) // R5
      && ctl.address_step_control[1:0] == 2'b01 && ctl.column_pointer == LAST_COL
      |=> ctl.column_pointer == 8'h00)
      else $error("column pointer did not wrap");
   chk_page_wrap: assert property ((data_wr || data_rd) // R6
      && ctl.address_step_control[2:0] == 3'b011 && ctl.page_pointer == LAST_PAGE
      |=> ctl.page_pointer == 7'h00)
      else $error("page pointer did not wrap to zero");
   chk_stat_rotate: assert property (stat_rd && stat_sel == 2'd2 |=> stat_sel == 2'd0) // R12
      else $error("status rotation did not restart");
   chk_trim_default: assert property (sw_reset |=> ctl.bias_trim == RST_TRIM // R24
      && state == ST_OPCODE)
      else $error("software reset left bias trim changed");
   chk_param_hold: assert property (cmd_wr && state == ST_OPCODE && cbyte == OP_TRIM // R25
      |=> state == ST_PARAM1 && opcode == OP_TRIM)
      else $error("trim opcode not held");
   chk_nvm_guard: assert property (nvm_on && cmd_wr && state == ST_PARAM1 // R20
      && opcode == OP_WIN_A |=> $stable(ctl.win_col_start))
      else $error("window written while nvm enabled");
   chk_esd_sticky: assert property (esd_strike |=> esd_event_flag [*3]) // R11
      else $error("ESD flag not held");
   chk_pump_valid: assert property (^ctl.pump_settings[1:0] == 1'b0 // R17
      && ^ctl.pump_settings[3:2] == 1'b0)
      else $error("pump setting holds an invalid code");

endmodule

// *** dv/lhcd_host.sv ***
// APB host model: one transfer per start pulse, result on done.
// Assumes the decoder sits on the same pclk and presetn.
`timescale 1ns/1ps
module lhcd_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             done,
   output logic [31:0]      rdata,
   output logic             err
);
   // Setup, then access held until pready; released only at that edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {psel, penable, done, pwrite, paddr, pwdata} <= '0;
      end else begin
         done <= 1'b0;
         if (psel && penable && pready) begin
            {psel, penable, done, rdata, err} <= {3'b001, prdata, pslverr};
         end else if (psel) begin
            penable <= 1'b1;
         end else if (start) begin
            {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, wdata};
         end
      end
   end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the decoder, driven through the host model.
`timescale 1ns/1ps
module tb;
   logic pclk, presetn, start, wr, done, err, psel, penable, pwrite, pready, pslverr;
   logic [7:0] addr, paddr, scroll, trim;
   logic [31:0] wdata, pwdata, prdata, rdata;
   logic [1:0] tc;
   logic [3:0] pump;
   logic [6:0] misc = 7'h01; // ESD, serial modes, nvm flags, chip select.
   int failures = 0, total_checks = 0, cyc = 0;
   logic [21:0] rows [10] = '{{8'h25,8'h00,2'd1,4'hf}, {8'h26,8'h00,2'd2,4'hf},
      {8'h27,8'h00,2'd3,4'hf}, {8'h24,8'h00,2'd0,4'hf}, {8'h28,8'h00,2'd0,4'hc},
      {8'h2c,8'h00,2'd0,4'h0}, {8'h2f,8'h00,2'd0,4'hc}, {8'h2b,8'h00,2'd0,4'hf},
      {8'h45,8'h05,2'd0,4'hf}, {8'h59,8'h95,2'd0,4'hf}};
   lhcd_host u_host (.pclk(pclk), .presetn(presetn), .start(start), .wr(wr), .addr(addr),
      .wdata(wdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .done(done),
      .rdata(rdata), .err(err));
   lhcd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .id_pin_state(2'b10), .bias_trim_offset(6'h15),
      .nvm_op_success(misc[3]), .nvm_option_present(misc[2]), .nvm_in_progress(misc[1]),
      .esd_strike(misc[6]), .serial_eight_bit_mode(misc[5]), .serial_nine_bit_mode(misc[4]),
      .chip_select_n(misc[0]), .esd_event_flag(), .scroll_offset(scroll),
      .temp_coefficient(tc), .pump_settings(pump), .bias_trim(trim), .display_control(),
      .panel_control());
   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; waits for the host to finish, with no timeout of its own beyond the cycle limit.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      {start, wr, addr, wdata} <= {1'b1, w, a, 24'h0, d};
      @(posedge pclk);
      start <= 1'b0;
      do @(negedge pclk); while (!done);
      @(posedge pclk);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin pclk = 1'b0; forever #4 pclk = ~pclk; end
   // A hang counts as a mismatch and closes the run.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin failures++; test_done(); end
   end
   initial begin
      {presetn, start, wr, addr, wdata} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({scroll, tc, pump, trim}, {8'h00, 2'd0, 4'hf, 8'hea});
      foreach (rows[i]) begin
         xfer(1'b1, 8'h00, rows[i][21:14]);
         check({scroll, tc, pump}, rows[i][13:0]);
      end
      $display("setting rows done");
      xfer(1'b1, 8'h00, 8'h81);
      xfer(1'b1, 8'h00, 8'h3c);
      check(trim, 8'h3c);
      // With nvm enabled the trim code loads the shared mask, window codes are eaten.
      xfer(1'b1, 8'h00, 8'hb8);
      xfer(1'b1, 8'h00, 8'h08);
      xfer(1'b1, 8'h00, 8'h81);
      xfer(1'b1, 8'h00, 8'hff);
      xfer(1'b1, 8'h00, 8'hf4);
      xfer(1'b1, 8'h00, 8'h12);
      xfer(1'b1, 8'h00, 8'h34);
      check(trim, 8'h3f);
      xfer(1'b1, 8'h00, 8'he2);
      check({scroll, tc, pump, trim}, {8'h00, 2'd0, 4'hf, 8'hea});
      foreach (rows[i]) if (i < 2) begin
         if (i == 1) xfer(1'b1, 8'h00, 8'h88);
         xfer(1'b1, 8'h00, 8'h0f);
         xfer(1'b1, 8'h00, 8'h1f);
         xfer(1'b1, 8'h04, 8'ha5);
         xfer(1'b0, 8'h08, 8'h00);
         check(rdata, i ? 32'h01ff : 32'h0100);
      end
      // First data read after addressing is a dummy; the second returns c3.
      xfer(1'b1, 8'h00, 8'h60);
      xfer(1'b1, 8'h00, 8'h0e);
      xfer(1'b1, 8'h04, 8'hc3);
      xfer(1'b1, 8'h00, 8'h0e);
      xfer(1'b0, 8'h04, 8'h00);
      xfer(1'b0, 8'h04, 8'h00);
      check(rdata, 32'h00c3);
      // Page-first stepping with wrap from the last page back to page zero.
      xfer(1'b1, 8'h00, 8'h8b);
      xfer(1'b1, 8'h00, 8'h6f);
      xfer(1'b1, 8'h00, 8'h74);
      xfer(1'b1, 8'h00, 8'h00);
      xfer(1'b1, 8'h04, 8'h5a);
      xfer(1'b0, 8'h08, 8'h00);
      check(rdata, 32'h00f1);
      $display("pointer tests done");
      misc <= 7'h41;
      @(posedge pclk);
      // Serial mode, chip selected, nvm flags set; status then streams on both addresses.
      misc <= 7'h2e;
      xfer(1'b1, 8'h00, 8'hfe);
      foreach (rows[i]) if (i < 4) begin
         xfer(1'b0, i[0] ? 8'h04 : 8'h00, 8'h00);
         check(rdata[7:0], i == 1 ? 8'h95 : i == 2 ? 8'ha1 : 8'h17);
      end
      xfer(1'b0, 8'h10, 8'h00);
      check(err, 1'b1);
      $display("status and error tests done");
      test_done();
   end
endmodule
